// *** design/parallel_io_port.sv ***
// 24-line programmable parallel port behind a classic Wishbone slave
// assumes pins are resolved outside from pinOut/pinOe; pinIn is async
//
// Contract
// - 24 lines in two groups of 12, each group's mode set separately.
// - basic mode: each group's three nibbles have their own direction.
// - strobed mode: 8 group lines form one byte, all in or all out.
// - strobed mode: three spare group lines carry strobe, flag, request.
// - bidir mode: 8 lines both ways, one line borrowed from group 1.
// - single-bit write drives one chosen output line high or low.
// - a byte port can serve a printer with strobed handshake lines.
`timescale 1ns/100ps
`include "ppio_map.svh"
module parallel_io_port (
   input wire logic clk_sys, // 10 MHz system clock
   input wire logic rst_n, // async reset, active low
   input wire logic cyc_i, // wishbone cycle
   input wire logic stb_i, // wishbone strobe
   input wire logic we_i, // wishbone write enable
   input wire logic [3:0] adr_i, // wishbone byte address
   input wire logic [3:0] sel_i, // wishbone byte lanes
   input wire logic [31:0] dat_i, // wishbone write data
   output logic [31:0] dat_o, // wishbone read data
   output logic ack_o, // wishbone acknowledge
   input wire logic [23:0] pinIn, // line levels from the connector
   output logic [23:0] pinOut, // line drive values
   output logic [23:0] pinOe // line drive enables, high drives
);
   localparam int NG = 2;

   ////////////////////////////////////////////////////////////////////
   // two-flop synchronisers on every line
   logic [23:0] sync1_r, sync2_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= '1;
         sync2_r <= '1;
      end else begin
         sync1_r <= pinIn;
         sync2_r <= sync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bus decode
   logic ack_r, ack_nxt;
   logic [31:0] datO_r, datO_nxt;
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [23:0] outReg_r, outReg_nxt;
   logic [3:0] adrWord;
   logic req, take, srHit;
   logic [23:0] srMask;
   logic [NG-1:0] swWrite, swRead;

   assign adrWord = {adr_i[3:2], 2'h0};
   // new request sees ack low; commit happens where ack is sampled
   assign req = cyc_i & stb_i & ~ack_r;
   assign take = cyc_i & stb_i & ack_r;
   assign srHit = take & we_i & (adrWord == `OFF_BITSR) & sel_i[0]
      & sel_i[1] & (dat_i[`SR_IDX] < `NUM_LINES);
   assign srMask = 24'h00_0001 << dat_i[`SR_IDX];

   // data byte strobes per group, lane g holds group g's byte
   always_comb begin
      for (int g = 0; g < NG; g++) begin
         swWrite[g] = take & we_i & (adrWord == `OFF_DATA) & sel_i[g];
         swRead[g] = take & ~we_i & (adrWord == `OFF_DATA) & sel_i[g];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // group configuration and handshake engines
   ppio_pkg::mode_t gMode [NG];
   logic [2:0] nDir [NG];
   logic [NG-1:0] bDir, inte, inDir, outDir, hsStbN, hsAckN;
   logic [NG-1:0] hsIbf, hsObfN, hsIntr;
   logic [7:0] hsLatch [NG];

   genvar gi;
   generate
      for (gi = 0; gi < NG; gi++) begin : grp
         localparam int CB = gi * `GRP_STRIDE;
         localparam int CL = `CTL_BASE + gi * `CTL_W;
         // group 1 never holds bidir, the write path refuses it
         assign gMode[gi] = ppio_pkg::mode_t'(ctrl_r[CB + `CF_MODE +: 2]);
         assign nDir[gi] = ctrl_r[CB + `CF_NDIR +: 3];
         assign bDir[gi] = ctrl_r[CB + `CF_BDIR];
         assign inte[gi] = ctrl_r[CB + `CF_INTE];
         assign inDir[gi] = (gMode[gi] == ppio_pkg::MODE_BIDIR)
            | ((gMode[gi] == ppio_pkg::MODE_STROBED) & ~bDir[gi]);
         assign outDir[gi] = (gMode[gi] == ppio_pkg::MODE_BIDIR)
            | ((gMode[gi] == ppio_pkg::MODE_STROBED) & bDir[gi]);
         assign hsStbN[gi] = sync2_r[CL + `C_STB];
         // bidir keeps the load strobe and moves ack to the spare line
         assign hsAckN[gi] = (gMode[gi] == ppio_pkg::MODE_BIDIR)
            ? sync2_r[CL + `C_SPARE] : sync2_r[CL + `C_STB];
         strobed_port #(
            .W(`BYTE_W)
         ) u_hs (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .inDir(inDir[gi]),
            .outDir(outDir[gi]),
            .inte(inte[gi]),
            .strobeN(hsStbN[gi]),
            .ackN(hsAckN[gi]),
            .pinData(sync2_r[gi * `BYTE_W +: `BYTE_W]),
            .swWrite(swWrite[gi]),
            .swRead(swRead[gi]),
            .latch(hsLatch[gi]),
            .ibf(hsIbf[gi]),
            .obfN(hsObfN[gi]),
            .intr(hsIntr[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // line drive: registered so the pins never glitch on decode
   logic [23:0] pinOut_r, pinOut_nxt, pinOe_r, pinOe_nxt;

   always_comb begin
      int d;
      int c;
      d = 0;
      c = 0;
      pinOut_nxt = outReg_r;
      pinOe_nxt = '0;
      for (int g = 0; g < NG; g++) begin
         d = g * `BYTE_W;
         c = `CTL_BASE + g * `CTL_W;
         case (gMode[g])
            ppio_pkg::MODE_STROBED: begin
               pinOe_nxt[d +: 8] = {8{bDir[g]}};
               pinOe_nxt[c + `C_FLAG] = 1'b1;
               pinOe_nxt[c + `C_INTR] = 1'b1;
               pinOut_nxt[c + `C_FLAG] = bDir[g] ? hsObfN[g] : hsIbf[g];
               pinOut_nxt[c + `C_INTR] = hsIntr[g];
               pinOe_nxt[c + `C_SPARE] = nDir[g][2];
            end
            ppio_pkg::MODE_BIDIR: begin
               // drive the byte only while the peripheral acks
               pinOe_nxt[d +: 8] = {8{~hsAckN[g]}};
               pinOe_nxt[c + `C_FLAG] = 1'b1;
               pinOe_nxt[c + `C_INTR] = 1'b1;
               pinOut_nxt[c + `C_FLAG] = hsIbf[g];
               pinOut_nxt[c + `C_INTR] = hsIntr[g];
            end
            default: begin
               pinOe_nxt[d +: 4] = {4{nDir[g][0]}};
               pinOe_nxt[d + 4 +: 4] = {4{nDir[g][1]}};
               pinOe_nxt[c +: 4] = {4{nDir[g][2]}};
            end
         endcase
      end
      // group 0 in bidir takes group 1's spare line for its out flag
      if (gMode[0] == ppio_pkg::MODE_BIDIR) begin
         pinOe_nxt[`BORROW_LINE] = 1'b1;
         pinOut_nxt[`BORROW_LINE] = hsObfN[0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pinOut_r <= '0;
         pinOe_r <= '0;
      end else begin
         pinOut_r <= pinOut_nxt;
         pinOe_r <= pinOe_nxt;
      end
   end

   assign pinOut = pinOut_r;
   assign pinOe = pinOe_r;

   ////////////////////////////////////////////////////////////////////
   // read-back: driven lines show their drive, others the pin,
   // strobed input and bidir bytes show the latched byte
   logic [23:0] rdLines;
   logic [31:0] rdStatus, rdMux;

   always_comb begin
      rdLines = (pinOe_r & pinOut_r) | (~pinOe_r & sync2_r);
      rdStatus = '0;
      for (int g = 0; g < NG; g++) begin
         if (inDir[g]) begin
            rdLines[g * `BYTE_W +: 8] = hsLatch[g];
         end
         rdStatus[g * `GRP_STRIDE + `ST_IBF] = hsIbf[g];
         rdStatus[g * `GRP_STRIDE + `ST_OBFN] = hsObfN[g];
         rdStatus[g * `GRP_STRIDE + `ST_INTR] = hsIntr[g];
      end
      case (adrWord)
         `OFF_DATA: rdMux = {8'h00, rdLines};
         `OFF_CTRL: rdMux = ctrl_r;
         `OFF_STATUS: rdMux = rdStatus;
         default: rdMux = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // register file, one wait state on every access
   always_comb begin
      ack_nxt = req;
      datO_nxt = datO_r;
      ctrl_nxt = ctrl_r;
      outReg_nxt = outReg_r;
      if (req & ~we_i) begin
         datO_nxt = rdMux;
      end
      if (take & we_i & (adrWord == `OFF_CTRL)) begin
         // each group owns one byte lane of the mode word
         for (int g = 0; g < NG; g++) begin
            if (sel_i[g]) begin
               ctrl_nxt[g * 8 +: 8] = dat_i[g * 8 +: 8];
            end
         end
         if (ctrl_nxt[`GRP_STRIDE + `CF_MODE +: 2]
               == ppio_pkg::MODE_BIDIR) begin
            ctrl_nxt[`GRP_STRIDE + `CF_MODE +: 2] = ppio_pkg::MODE_BASIC;
         end
      end
      if (take & we_i & (adrWord == `OFF_DATA)) begin
         for (int b = 0; b < 3; b++) begin
            if (sel_i[b]) begin
               outReg_nxt[b * 8 +: 8] = dat_i[b * 8 +: 8];
            end
         end
      end
      // touch one bit only, the rest of the port keeps its value
      if (srHit) begin
         outReg_nxt[dat_i[`SR_IDX]] = dat_i[`SR_VAL];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         datO_r <= '0;
         ctrl_r <= `CTRL_RST;
         outReg_r <= `OUT_RST;
      end else begin
         ack_r <= ack_nxt;
         datO_r <= datO_nxt;
         ctrl_r <= ctrl_nxt;
         outReg_r <= outReg_nxt;
      end
   end

   assign ack_o = ack_r;
   assign dat_o = datO_r;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_sr_single: assert property (
      srHit |=> ((outReg_r ^ $past(outReg_r)) & ~$past(srMask)) == '0)
      else $error("single-bit write disturbed other lines");
   chk_sr_value: assert property (
      srHit |=> (|(outReg_r & $past(srMask))) == $past(dat_i[`SR_VAL]))
      else $error("single-bit write did not set the level");
   chk_grp_indep: assert property (
      take && we_i && adrWord == `OFF_CTRL && sel_i[1:0] == 2'h1
      |=> ctrl_r[15:8] == $past(ctrl_r[15:8]))
      else $error("group 0 config write altered group 1");
   chk_nibble_dir: assert property (
      gMode[1] == ppio_pkg::MODE_BASIC && gMode[0] != ppio_pkg::MODE_BIDIR
      |=> pinOe[15:12] == {4{$past(nDir[1][1])}}
         && pinOe[23:20] == {4{$past(nDir[1][2])}})
      else $error("nibble drive does not follow its direction");
   chk_byte_dir: assert property (
      gMode[0] == ppio_pkg::MODE_STROBED
      |=> pinOe[7:0] == {8{$past(bDir[0])}})
      else $error("strobed byte not uniformly in or out");
   chk_hs_lines: assert property (
      gMode[0] == ppio_pkg::MODE_STROBED |=> pinOe[18:16] == 3'h6
         && pinOut[18] == $past(hsIntr[0]))
      else $error("strobed control lines misassigned");
   chk_borrow: assert property (
      gMode[0] == ppio_pkg::MODE_BIDIR
      |=> pinOe[`BORROW_LINE] && pinOut[`BORROW_LINE] == $past(hsObfN[0]))
      else $error("borrowed line not driven with out flag");
   chk_bus_ack: assert property (
      cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("bus answer not a single cycle after request");
   // a refused single-bit write must leave every output bit alone
   chk_sr_refuse: assert property (
      take && we_i && adrWord == `OFF_BITSR && !srHit
      |=> outReg_r == $past(outReg_r))
      else $error("refused single-bit write changed outputs");
   // bidir byte drive follows the synchronised ack line
   chk_bidir_drive: assert property (
      gMode[0] == ppio_pkg::MODE_BIDIR
      |=> pinOe[7:0] == {8{!$past(hsAckN[0])}})
      else $error("bidir byte drive does not follow ack");
   // strobed output byte of group 1 shows the output register
   chk_byte_out: assert property (
      gMode[1] == ppio_pkg::MODE_STROBED && bDir[1]
      |=> pinOut[15:8] == $past(outReg_r[15:8]))
      else $error("strobed output byte not from output register");
endmodule

// *** design/ppio_map.svh ***
// register offsets, field positions and reset values of the parallel port
// included by the port top level and by the bench top level
`ifndef PPIO_MAP_SVH
`define PPIO_MAP_SVH
`define OFF_DATA 4'h0
`define OFF_CTRL 4'h4
`define OFF_BITSR 4'h8
`define OFF_STATUS 4'hC
`define CTRL_RST 32'h0000_0000
`define OUT_RST 24'h00_0000
`define GRP_STRIDE 8
`define CF_MODE 0
`define CF_NDIR 2
`define CF_BDIR 5
`define CF_INTE 6
`define ST_IBF 0
`define ST_OBFN 1
`define ST_INTR 2
`define SR_IDX 4:0
`define SR_VAL 8
`define BYTE_W 8
`define CTL_BASE 16
`define CTL_W 4
`define NUM_LINES 24
`define BORROW_LINE 23
`define C_STB 0
`define C_FLAG 1
`define C_INTR 2
`define C_SPARE 3
`endif

// *** design/ppio_pkg.sv ***
// types shared by the parallel port design files
// assumes only a SystemVerilog compiler
package ppio_pkg;
   typedef enum logic [1:0] {
      MODE_BASIC = 2'b00,
      MODE_STROBED = 2'b01,
      MODE_BIDIR = 2'b10
   } mode_t;
endpackage

// *** design/strobed_port.sv ***
// byte-wide strobed handshake of one port group: input latch with
// buffer-full flag, output buffer-full flag, and the request line
// assumes strobe and ack already synchronised to clk_sys, idle high
`timescale 1ns/100ps
module strobed_port #(
   parameter int W = 8
) (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic inDir, // strobed input direction active
   input wire logic outDir, // strobed output direction active
   input wire logic inte, // request line enable
   input wire logic strobeN, // peripheral load strobe, active low
   input wire logic ackN, // peripheral acknowledge, active low
   input wire logic [W-1:0] pinData, // synchronised data lines
   input wire logic swWrite, // software wrote the data byte
   input wire logic swRead, // software read the data byte
   output logic [W-1:0] latch, // byte caught by the strobe
   output logic ibf, // input buffer full
   output logic obfN, // output buffer full, active low
   output logic intr // request to the processor side
);
   logic stbPrev_r, stbPrev_nxt, ackPrev_r, ackPrev_nxt;
   logic ibf_r, ibf_nxt, obfN_r, obfN_nxt;
   logic intIn_r, intIn_nxt, intOut_r, intOut_nxt, intr_r, intr_nxt;
   logic [W-1:0] latch_r, latch_nxt;
   logic stbFall, stbRise, ackFall, ackRise;

   assign stbFall = stbPrev_r & ~strobeN;
   assign stbRise = ~stbPrev_r & strobeN;
   assign ackFall = ackPrev_r & ~ackN;
   assign ackRise = ~ackPrev_r & ackN;

   // handshake flags: hardware sets win over software clears
   always_comb begin
      stbPrev_nxt = strobeN;
      ackPrev_nxt = ackN;
      latch_nxt = latch_r;
      ibf_nxt = 1'b0;
      intIn_nxt = 1'b0;
      obfN_nxt = 1'b1;
      intOut_nxt = 1'b0;
      if (inDir) begin
         if (stbFall) begin
            latch_nxt = pinData;
         end
         ibf_nxt = stbFall | (ibf_r & ~swRead);
         intIn_nxt = (stbRise & ibf_r) | (intIn_r & ~swRead);
      end
      if (outDir) begin
         // a fresh write wins, the new byte must still be taken
         if (swWrite) begin
            obfN_nxt = 1'b0;
         end else if (ackFall) begin
            obfN_nxt = 1'b1;
         end else begin
            obfN_nxt = obfN_r;
         end
         intOut_nxt = (ackRise & obfN_r) | (intOut_r & ~swWrite);
      end
      intr_nxt = inte & (intIn_nxt | intOut_nxt);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stbPrev_r <= 1'b1;
         ackPrev_r <= 1'b1;
         latch_r <= '0;
         ibf_r <= 1'b0;
         obfN_r <= 1'b1;
         intIn_r <= 1'b0;
         intOut_r <= 1'b0;
         intr_r <= 1'b0;
      end else begin
         stbPrev_r <= stbPrev_nxt;
         ackPrev_r <= ackPrev_nxt;
         latch_r <= latch_nxt;
         ibf_r <= ibf_nxt;
         obfN_r <= obfN_nxt;
         intIn_r <= intIn_nxt;
         intOut_r <= intOut_nxt;
         intr_r <= intr_nxt;
      end
   end

   assign latch = latch_r;
   assign ibf = ibf_r;
   assign obfN = obfN_r;
   assign intr = intr_r;

   ////////////////////////////////////////////////////////////////////
   // checks on the handshake
   sequence loadEdge;
      inDir && stbFall;
   endsequence
   sequence wrOut;
      outDir && swWrite;
   endsequence
   sequence ackOut;
      outDir && ackFall && !swWrite;
   endsequence

   chk_load_latch: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      loadEdge |=> ibf_r && latch_r == $past(pinData))
      else $error("strobe did not latch byte or set full flag");
   chk_obf_set: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      wrOut |=> !obfN_r ##1 (!obfN_r || $past(ackFall)))
      else $error("output full flag not raised after write");
   chk_obf_clear: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      ackOut ##1 outDir |-> obfN_r)
      else $error("output full flag not released by ack");
endmodule

// *** tb/peri_model.sv ***
// far-side peripheral: bench line levels plus strobed byte handshakes
// assumes the device wins any line it enables; pinIn is the wire level
`timescale 1ns/100ps
module peri_model (
   input wire logic clk_sys, // system clock
   input wire logic [23:0] pinOut, // device drive values
   input wire logic [23:0] pinOe, // device drive enables
   input wire logic [23:0] baseVal, // bench line values
   input wire logic [23:0] baseEn, // bench line enables
   input wire logic sendReq, // offer one byte on group0
   input wire logic [7:0] sendByte, // byte offered
   input wire logic takeOn, // answer the out flag with ack
   input wire logic slow, // stretch each handshake step
   output logic [23:0] pinIn, // resolved line levels
   output logic [7:0] gotByte, // last byte taken
   output logic [7:0] gotCnt // bytes taken
);
   logic [23:0] drv;
   logic [23:0] en;
   logic [23:0] junk;
   int hold;
   ////////////////////////////////////////////////////////////////////////
   // undriven lines flip every cycle so a stale level never passes
   initial junk = 24'h5A_A5A5;
   always @(posedge clk_sys) junk <= ~junk;
   assign hold = slow ? 6 : 2;
   // device first, then bench, then handshake drivers
   assign pinIn = (pinOe & pinOut) | (~pinOe & baseEn & baseVal)
      | (~pinOe & ~baseEn & en & drv) | (~pinOe & ~baseEn & ~en & junk);
   ////////////////////////////////////////////////////////////////////////
   // strobe/ack line idles high; data held around the strobe low time
   initial begin
      drv = 24'h01_0000;
      en = 24'h01_0000;
      gotByte = 8'h00;
      gotCnt = 8'h00;
      forever begin
         @(posedge clk_sys);
         if (sendReq) begin
            drv[7:0] <= sendByte;
            en[7:0] <= 8'hFF;
            repeat (hold) @(posedge clk_sys);
            drv[16] <= 1'b0;
            repeat (hold) @(posedge clk_sys);
            drv[16] <= 1'b1;
            repeat (hold) @(posedge clk_sys);
            en[7:0] <= 8'h00;
         end else if (takeOn && pinOe[17] && !pinOut[17]) begin
            repeat (hold) @(posedge clk_sys);
            gotByte <= pinOut[7:0];
            drv[16] <= 1'b0;
            while (pinOut[17] !== 1'b1) @(posedge clk_sys);
            repeat (hold) @(posedge clk_sys);
            drv[16] <= 1'b1;
            gotCnt <= gotCnt + 8'h01;
         end
      end
   end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the 24-line parallel port
// assumes design files and peri_model are compiled before it
`timescale 1ns/100ps
`include "ppio_map.svh"
module tb_top;
   logic clk_sys, rst_n, cyc, stb, we, ack, sendReq, takeOn, slow;
   logic [3:0] adr, sel;
   logic [31:0] wdat, datO;
   logic [23:0] pinOut, pinOe, pinIn, baseVal, baseEn;
   logic [7:0] sendByte, gotByte, gotCnt;
   int err_total = 0;
   int check_count = 0;
   ////////////////////////////////////////////////////////////////////////
   parallel_io_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(datO), .ack_o(ack), .pinIn(pinIn), .pinOut(pinOut),
      .pinOe(pinOe));
   peri_model u_peri (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe),
      .baseVal(baseVal), .baseEn(baseEn), .sendReq(sendReq),
      .sendByte(sendByte), .takeOn(takeOn), .slow(slow), .pinIn(pinIn),
      .gotByte(gotByte), .gotCnt(gotCnt));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what,
            got, exp);
      end
   endtask
   // classic cycle: request held until ack is sampled high
   task automatic wb(input logic w, input logic [3:0] a,
      input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      @(posedge clk_sys);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      q = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) chk(32'h1, 32'h0, "no ack");
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, s, d, q);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      wb(1'b0, a, 4'hF, 32'h0, q);
   endtask
   // status polled a bounded number of times
   task automatic poll(input logic [31:0] m);
      logic [31:0] q;
      q = 32'h0;
      for (int n = 0; n < 40 && (q & m) === 32'h0; n++) rd(`OFF_STATUS, q);
      chk(q & m, m, "status wait");
   endtask
   task automatic offer(input logic [7:0] b);
      sendByte <= b;
      sendReq <= 1'b1;
      @(posedge clk_sys);
      sendReq <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] q;
      chk({8'h00, pinOe}, 32'h0, "oe after reset");
      chk({8'h00, pinOut}, {8'h00, `OUT_RST}, "out after reset");
      rd(`OFF_CTRL, q);
      chk(q, `CTRL_RST, "ctrl after reset");
   endtask
   // groups set apart; nibble dirs; bit set/reset incl. bad index
   task automatic t_basic();
      logic [31:0] q;
      logic [23:0] sh, oe;
      int idx [6] = '{0, 13, 17, 23, 24, 31};
      logic [5:0] vb = 6'b011010;
      sh = 24'h06_C3A9;
      oe = 24'h0F_F00F;
      baseVal <= 24'hA5_5A5A;
      baseEn <= 24'hFF_FFFF;
      wr(`OFF_CTRL, 4'hF, 32'hFFFF_0A14);
      rd(`OFF_CTRL, q);
      chk(q, 32'h0000_0814, "ctrl readback");
      wr(`OFF_DATA, 4'h7, {8'h00, sh});
      repeat (5) @(posedge clk_sys);
      chk({8'h00, pinOe}, {8'h00, oe}, "nibble dirs");
      chk({8'h00, pinOut & oe}, {8'h00, sh & oe}, "nibble out");
      rd(`OFF_DATA, q);
      chk({8'h00, q[23:0]}, {8'h00, (sh & oe) | (24'hA5_5A5A & ~oe)},
         "line readback");
      for (int i = 0; i < 6; i++) begin
         wr(`OFF_BITSR, 4'h3, {23'h0, vb[i], 3'h0, idx[i][4:0]});
         if (idx[i] < 24) sh[idx[i]] = vb[i];
         repeat (3) @(posedge clk_sys);
         chk({8'h00, pinOut & oe}, {8'h00, sh & oe}, "bit write");
      end
      rd(`OFF_BITSR, q);
      chk(q, 32'h0, "bitsr read");
   endtask
   // strobed input byte: full flag, request, cleared by the read
   task automatic t_sin(input logic sl, input logic [7:0] b);
      logic [31:0] q;
      slow <= sl;
      baseEn <= 24'hF0_FF00;
      wr(`OFF_CTRL, 4'hF, 32'h0000_0041);
      offer(b);
      poll(32'h1);
      repeat (16) @(posedge clk_sys);
      chk({30'h0, pinOe[18:17]}, 32'h3, "flag lines driven");
      chk({30'h0, pinOut[18:17]}, 32'h3, "full and request");
      rd(`OFF_DATA, q);
      chk({24'h0, q[7:0]}, {24'h0, b}, "strobed byte");
      repeat (3) @(posedge clk_sys);
      chk({30'h0, pinOut[18:17]}, 32'h0, "flags cleared");
   endtask
   // printer-style output, two bytes, slow acknowledge
   task automatic t_sout();
      logic [31:0] q;
      logic [7:0] c;
      logic [7:0] bs [2] = '{8'h96, 8'h69};
      slow <= 1'b1;
      takeOn <= 1'b1;
      wr(`OFF_CTRL, 4'hF, 32'h0000_0061);
      for (int i = 0; i < 2; i++) begin
         c = gotCnt;
         wr(`OFF_DATA, 4'h1, {24'h0, bs[i]});
         rd(`OFF_STATUS, q);
         chk({29'h0, q[2:0]}, 32'h0, "full, request gone");
         for (int n = 0; n < 60 && gotCnt === c; n++) @(posedge clk_sys);
         chk({24'h0, gotByte}, {24'h0, bs[i]}, "printer byte");
         repeat (16) @(posedge clk_sys);
         rd(`OFF_STATUS, q);
         chk({29'h0, q[2:0]}, 32'h6, "empty, request up");
      end
      chk({24'h0, pinOe[7:0]}, 32'hFF, "byte driven");
      takeOn <= 1'b0;
   endtask
   // bidirectional bus with the borrowed flag line
   task automatic t_bidir();
      logic [31:0] q;
      slow <= 1'b0;
      baseEn <= 24'hF8_FF00;
      baseVal <= 24'h08_0000;
      wr(`OFF_CTRL, 4'hF, 32'h0000_0042);
      wr(`OFF_DATA, 4'h1, 32'h0000_005A);
      repeat (5) @(posedge clk_sys);
      chk({24'h0, pinOe[7:0]}, 32'h0, "bus released");
      chk({30'h0, pinOe[23], pinOut[23]}, 32'h2, "borrowed flag");
      baseVal <= 24'h00_0000;
      repeat (5) @(posedge clk_sys);
      chk({16'h0, pinOe[7:0], pinOut[7:0]}, 32'hFF5A, "bus on ack");
      chk({31'h0, pinOut[23]}, 32'h1, "flag empty");
      baseVal <= 24'h08_0000;
      repeat (5) @(posedge clk_sys);
      chk({24'h0, pinOe[7:0]}, 32'h0, "bus off again");
      offer(8'hA6);
      poll(32'h1);
      rd(`OFF_DATA, q);
      chk({24'h0, q[7:0]}, 32'hA6, "bidir input");
   endtask
   // group 1 strobed output on its own lines; mode 3 acts as basic
   task automatic t_grp1();
      logic [31:0] q;
      baseVal <= 24'h18_0000;
      // let the raised ack settle before the mode switch
      repeat (4) @(posedge clk_sys);
      wr(`OFF_CTRL, 4'hF, 32'h0000_6103);
      wr(`OFF_CTRL, 4'h1, 32'h0000_0A03);
      rd(`OFF_CTRL, q);
      chk(q, 32'h0000_6103, "g1 config kept");
      wr(`OFF_DATA, 4'h2, 32'h0000_C300);
      repeat (5) @(posedge clk_sys);
      chk({8'h00, pinOe}, 32'h0060_FF00, "g1 strobed drive");
      chk({23'h0, pinOut[21], pinOut[15:8]}, 32'h0C3, "g1 full");
      baseVal <= 24'h08_0000;
      repeat (5) @(posedge clk_sys);
      chk({30'h0, pinOut[22:21]}, 32'h1, "g1 acked");
      baseVal <= 24'h18_0000;
      repeat (5) @(posedge clk_sys);
      chk({30'h0, pinOut[22:21]}, 32'h3, "g1 request");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // whole run is well under 3000 cycles
   initial begin
      repeat (6000) @(posedge clk_sys);
      err_total++;
      give_verdict();
   end
   initial begin
      {rst_n, cyc, stb, we, sendReq, takeOn, slow} = 7'h00;
      {adr, sel, wdat, sendByte} = 48'h0;
      baseVal = 24'h00_0000;
      baseEn = 24'h00_0000;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_basic();
      t_sin(1'b0, 8'h3C);
      t_sin(1'b1, 8'hC3);
      t_sout();
      t_bidir();
      t_grp1();
      give_verdict();
   end
endmodule
